// file: spd_core.sv
// Purpose: control register and latched diagnostics with overload cycling
// Assumes: analog comparators arrive asynchronous; host bus decoded outside
// Notes: register access is a write strobe and a read strobe, same clock
// Notes on behaviour
// - five diagnostic flags are readable as status and are low normally.
// - overload, overtemp and power-not-good latch until cause gone and read.
// - a three-bit control field picks the output voltage.
// - output-low flag is high while output enabled and level below limits.
// - pull-down overcurrent longer than the sink timeout sets its flag.
// - during undervoltage lockout writes are ignored and control is zero.
// - the host interface logic resets itself at power-on.
// - above the release threshold writes are accepted again.
// - input supply below the low power threshold sets power-not-good.
// - one control bit picks compensation, zero electrolytic, one ceramic.
// - on overload output stays on for the on time, then off for off time.
// - after off the output runs another on time, repeating if overloaded.
// - a clean on time returns to normal; the flag clears on a later read.
// - overtemperature disables converter and regulator and sets its flag.
// - overtemperature recovery is automatic; flag clears on a later read.
`timescale 1ns/10ps
`default_nettype none
module spd_core
    import spd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic ctrl_wr,
    input wire logic [CTRL_W-1:0] ctrl_wdata,
    input wire logic status_rd,
    input wire logic overload_in,
    input wire logic overtemp_in,
    input wire logic undervoltage_lockout,
    input wire logic out_below_in,
    input wire logic sink_overcur_in,
    input wire logic low_power_threshold,
    output logic [VSEL_W-1:0] vsel,
    output logic comp_ceramic,
    output logic power_enable,
    output logic [STATUS_W-1:0] status,
    output logic overload_flag,
    output logic overtemp_flag,
    output logic output_low_flag,
    output logic pulldown_overcurrent_flag,
    output logic power_not_good_flag
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [5:0] raw_in, sync1, sync2;
    assign raw_in = {low_power_threshold, sink_overcur_in, out_below_in,
                     undervoltage_lockout, overtemp_in, overload_in};
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else if (clk_en) begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end
    wire logic ovl_s = sync2[0];
    wire logic otp_s = sync2[1];
    wire logic undervoltage_lockout_s = sync2[2];
    wire logic low_s = sync2[3];
    wire logic sink_s = sync2[4];
    wire logic png_s = sync2[5];

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    // sys_rst stands for the power-on reset of the interface
    logic [CTRL_W-1:0] ctrl;
    wire logic wr_ok = ctrl_wr && !undervoltage_lockout_s;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET;
        end else if (clk_en) begin
            if (undervoltage_lockout_s) begin
                ctrl <= CTRL_RESET;
            end else if (wr_ok) begin
                ctrl <= ctrl_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // overload on/off sequencer
    // ----------------------------------------------------------------
    spd_prot_type state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic seen_ovl, next_seen;
    wire logic on_done = (cnt == CNT_W'(T_ON_CYC - 1));
    wire logic off_done = (cnt == CNT_W'(T_OFF_CYC - 1));
    wire logic enter_off = (state == SPD_ON_WIN) && on_done
                           && (seen_ovl || ovl_s);
    always_comb begin
        next_state = state;
        next_cnt = cnt + CNT_W'(1);
        next_seen = seen_ovl | ovl_s;
        case (state)
            SPD_NORMAL: begin
                next_cnt = '0;
                next_seen = 1'b0;
                if (ovl_s) begin
                    next_state = SPD_ON_WIN;
                    next_seen = 1'b1;
                end
            end
            SPD_ON_WIN: begin
                if (on_done) begin
                    next_cnt = '0;
                    next_seen = 1'b0;
                    if (seen_ovl || ovl_s)
                        next_state = SPD_OFF_WIN;
                    else
                        next_state = SPD_NORMAL;
                end
            end
            SPD_OFF_WIN: begin
                next_seen = 1'b0;
                if (off_done) begin
                    next_cnt = '0;
                    next_state = SPD_ON_WIN;
                end
            end
            default: begin
                next_state = SPD_NORMAL;
                next_cnt = '0;
                next_seen = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= SPD_NORMAL;
            cnt <= '0;
            seen_ovl <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            cnt <= next_cnt;
            seen_ovl <= next_seen;
        end
    end

    // ----------------------------------------------------------------
    // sink timeout
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] sink_cnt;
    wire logic sink_expired = (sink_cnt == CNT_W'(T_SINK_CYC));
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sink_cnt <= '0;
        end else if (clk_en) begin
            if (!sink_s)
                sink_cnt <= '0;
            else if (!sink_expired)
                sink_cnt <= sink_cnt + CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // flags and outputs
    // ----------------------------------------------------------------
    // latched flags: the cause holding or arriving wins over a read
    wire logic next_ovl_f = enter_off
                            | (overload_flag & ~status_rd)
                            | (overload_flag & (state != SPD_NORMAL));
    wire logic next_otp_f = otp_s | (overtemp_flag & ~status_rd);
    wire logic next_png_f = png_s | (power_not_good_flag & ~status_rd);
    wire logic pwr_ok = ctrl != CTRL_RESET;
    wire logic next_pwr = pwr_ok && !otp_s && !undervoltage_lockout_s
                          && (next_state != SPD_OFF_WIN);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overload_flag <= 1'b0;
            overtemp_flag <= 1'b0;
            power_not_good_flag <= 1'b0;
            output_low_flag <= 1'b0;
            pulldown_overcurrent_flag <= 1'b0;
            vsel <= '0;
            comp_ceramic <= 1'b0;
            power_enable <= 1'b0;
            status <= '0;
        end else if (clk_en) begin
            overload_flag <= next_ovl_f;
            overtemp_flag <= next_otp_f;
            power_not_good_flag <= next_png_f;
            output_low_flag <= power_enable & low_s;
            pulldown_overcurrent_flag <= sink_expired;
            vsel <= ctrl[VSEL_LSB +: VSEL_W];
            comp_ceramic <= ctrl[COMP_BIT];
            power_enable <= next_pwr;
            status <= {next_png_f, sink_expired, power_enable & low_s,
                       next_otp_f, next_ovl_f};
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_undervoltage_lockout_ctrl_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && undervoltage_lockout_s |=> ctrl == CTRL_RESET)
        else $error("control not cleared under lockout");
    a_otp_power_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && otp_s |=> !power_enable)
        else $error("power left on in overtemperature");
    a_otp_flag_set: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && otp_s |=> overtemp_flag)
        else $error("overtemp flag not set");
    a_otp_flag_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && overtemp_flag && !status_rd |=> overtemp_flag)
        else $error("overtemp flag dropped without read");
    a_png_flag_set: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && png_s |=> power_not_good_flag)
        else $error("power not good flag missing");
    a_off_no_power: assert property (
        @(posedge clk) disable iff (sys_rst)
        state == SPD_OFF_WIN |-> !power_enable)
        else $error("output on during off interval");
    a_off_sets_flag: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && enter_off |=> overload_flag && state == SPD_OFF_WIN)
        else $error("off interval without overload flag");
    a_off_to_on: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && state == SPD_OFF_WIN && off_done |=> state == SPD_ON_WIN)
        else $error("off interval did not return to on");
    a_ctrl_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && wr_ok |=> ctrl == $past(ctrl_wdata))
        else $error("control write lost");
    a_vsel_follow: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en |=> vsel == $past(ctrl[VSEL_LSB +: VSEL_W]))
        else $error("voltage select does not follow control");
    c_overload_cycle: cover property (@(posedge clk) enter_off);
    c_overload_clear: cover property (@(posedge clk)
        state == SPD_ON_WIN && on_done && !seen_ovl && !ovl_s);
    c_sink_timeout: cover property (@(posedge clk) sink_expired);
    c_flag_read: cover property (@(posedge clk)
        overtemp_flag && status_rd && !otp_s);
endmodule // spd_core
`default_nettype wire

// file: spd_host_model.sv
// Purpose: host side model issuing control writes and status reads
// Assumes: one-cycle strobes sampled on the rising clock edge
// Notes: strobes change just after an edge and span one full cycle
`timescale 1ns/10ps
`default_nettype none
module spd_host_model
    import spd_pkg::*;
(
    input wire logic clk,
    output var logic ctrl_wr,
    output var logic [CTRL_W-1:0] ctrl_wdata,
    output var logic status_rd
);
    initial begin
        ctrl_wr = 1'b0;
        ctrl_wdata = 4'h0;
        status_rd = 1'b0;
    end
    // whole word per write; the device alone decides if it is taken
    task automatic write_ctrl(input logic [CTRL_W-1:0] w);
        @(posedge clk);
        ctrl_wr <= 1'b1;
        ctrl_wdata <= w;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        // data no longer qualified, so do not leave the old word standing
        ctrl_wdata <= ~w;
    endtask
    task automatic read_status();
        @(posedge clk);
        status_rd <= 1'b1;
        @(posedge clk);
        status_rd <= 1'b0;
    endtask
endmodule // spd_host_model
`default_nettype wire

// file: spd_pkg.sv
// Purpose: constants for the supply protection and diagnostic core
// Assumes: 50 MHz system clock
// Notes: timing counts derive from times in their own units
`default_nettype none
package spd_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int T_ON_MS = 90;
    localparam int T_OFF_MS = 900;
    localparam int T_SINK_MS = 10;
    localparam int T_ON_CYC = T_ON_MS * (CLK_HZ / 1000);
    localparam int T_OFF_CYC = T_OFF_MS * (CLK_HZ / 1000);
    localparam int T_SINK_CYC = T_SINK_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 26;
    // control word layout
    localparam int VSEL_LSB = 0;
    localparam int VSEL_W = 3;
    localparam int COMP_BIT = 3;
    localparam int CTRL_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
    // status word layout
    localparam int ST_OVERLOAD = 0;
    localparam int ST_OVERTEMP = 1;
    localparam int ST_OUT_LOW = 2;
    localparam int ST_PULLDOWN = 3;
    localparam int ST_PNG = 4;
    localparam int STATUS_W = 5;
    typedef enum logic [2:0] {
        SPD_NORMAL = 3'b001,
        SPD_ON_WIN = 3'b010,
        SPD_OFF_WIN = 3'b100
    } spd_prot_type;
endpackage
`default_nettype wire

// file: supply_protection_diag_ctrl_tb_top.sv
// Purpose: self-checking bench for the protection and diagnostic core
// Assumes: fixed counts, so long protection windows are only entered
// Notes: cond bits are overload, overtemp, lockout, low, sink, supply
`timescale 1ns/10ps
`default_nettype none
module supply_protection_diag_ctrl_tb_top
    import spd_pkg::*;
;
    logic clk, sys_rst, clk_en, ctrl_wr, status_rd;
    logic [5:0] cond;
    logic [CTRL_W-1:0] ctrl_wdata, w;
    logic [VSEL_W-1:0] vsel;
    logic [STATUS_W-1:0] status;
    logic comp_ceramic, power_enable, ol_f, ot_f, low_f, pd_f, png_f;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    spd_host_model u_host (.clk(clk), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .status_rd(status_rd));
    spd_core u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .status_rd(status_rd),
        .overload_in(cond[0]), .overtemp_in(cond[1]),
        .undervoltage_lockout(cond[2]), .out_below_in(cond[3]),
        .sink_overcur_in(cond[4]), .low_power_threshold(cond[5]),
        .vsel(vsel), .comp_ceramic(comp_ceramic),
        .power_enable(power_enable), .status(status),
        .overload_flag(ol_f), .overtemp_flag(ot_f),
        .output_low_flag(low_f), .pulldown_overcurrent_flag(pd_f),
        .power_not_good_flag(png_f));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // settle one step past the edge so freshly updated outputs are read
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_cond(input int c, input logic v);
        @(posedge clk);
        cond[c] <= v;
    endtask
    function automatic logic exp_pe(input logic [CTRL_W-1:0] x);
        return x != 4'h0;
    endfunction
    task automatic wr_chk(input logic [CTRL_W-1:0] x);
        u_host.write_ctrl(x);
        wait_n(3);
        chk(vsel, x[2:0]);
        chk(comp_ceramic, x[3]);
        chk(power_enable, exp_pe(x));
    endtask
    // latched flag: holds while the cause stands and until a later read
    task automatic latch_case(input int c, input int b);
        set_cond(c, 1'b1);
        wait_n(6);
        chk(status[b], 1'b1);
        if (c == 1) chk({power_enable, ot_f}, 2'h1);
        u_host.read_status();
        wait_n(3);
        chk(status[b], 1'b1);
        set_cond(c, 1'b0);
        wait_n(6);
        chk(status[b], 1'b1);
        if (c == 1) chk(power_enable, 1'b1);
        u_host.read_status();
        wait_n(3);
        chk(status[b], 1'b0);
        chk({ot_f, png_f}, 2'h0);
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        cond = 6'h0;
        void'($urandom(32'h415DA178));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        wait_n(3);
        chk(status, 5'h00);
        chk({vsel, comp_ceramic, power_enable}, 5'h00);
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($urandom);
            wr_chk(w);
        end
        wr_chk(4'h5);
        @(posedge clk);
        clk_en <= 1'b0;
        u_host.write_ctrl(4'hA);
        wait_n(3);
        chk(vsel, 3'h5);
        @(posedge clk);
        clk_en <= 1'b1;
        set_cond(2, 1'b1);
        wait_n(5);
        chk({vsel, comp_ceramic, power_enable}, 5'h00);
        u_host.write_ctrl(4'hF);
        wait_n(4);
        chk({vsel, power_enable}, 4'h0);
        set_cond(2, 1'b0);
        wait_n(4);
        wr_chk(4'h6);
        set_cond(3, 1'b1);
        wait_n(5);
        chk({low_f, status[ST_OUT_LOW]}, 2'h3);
        wr_chk(4'h0);
        wait_n(2);
        chk(low_f, 1'b0);
        set_cond(3, 1'b0);
        wr_chk(4'h2);
        latch_case(1, ST_OVERTEMP);
        latch_case(5, ST_PNG);
        set_cond(4, 1'b1);
        wait_n(100);
        chk({pd_f, status[ST_PULLDOWN]}, 2'h0);
        set_cond(4, 1'b0);
        set_cond(0, 1'b1);
        for (int i = 0; i < 60; i++) begin
            wait_n(1);
            chk(power_enable, 1'b1);
        end
        chk({ol_f, status[ST_OVERLOAD]}, 2'h0);
        // mid-run reset: everything back to the power-on state
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        wait_n(1);
        chk({vsel, comp_ceramic, power_enable}, 5'h00);
        chk({ol_f, status}, 6'h00);
        tally_and_finish();
    end
endmodule // supply_protection_diag_ctrl_tb_top
`default_nettype wire
